// *** rtl/fcs_flash_cmd_seq.v ***
/*
 * Flash command sequencer with a 2 KB byte array, one-deep command buffer,
 * write-once timebase divider, block protection and a level interrupt.
 * Assumes an APB master on REF_CLK; array byte n sits at word n of the
 * array window.
 */
`include "fcs_map.vh"
`timescale 1ns/1ps
`default_nettype none

module fcs_flash_cmd_seq (
    input  wire        REF_CLK,
    input  wire        RESET,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [15:0] PADDR,
    input  wire [31:0] PWDATA,
    output wire        PREADY,
    output reg  [31:0] PRDATA,
    output reg         PSLVERR,
    output wire        IRQ
);

// ***************************************************
// state
// ***************************************************
    localparam SEQ_IDLE = 2'b00;
    localparam SEQ_ADDR = 2'b01;
    localparam SEQ_CMD  = 2'b10;

    reg [7:0]  mem [0:2047];
    reg [1:0]  seq_ff;
    reg [10:0] lat_addr_ff;
    reg [7:0]  lat_data_ff;
    reg [7:0]  lat_cmd_ff;
    reg        buf_v_ff;
    reg [10:0] buf_addr_ff;
    reg [7:0]  buf_data_ff;
    reg [7:0]  buf_cmd_ff;
    reg        act_v_ff;
    reg [10:0] act_addr_ff;
    reg [7:0]  act_data_ff;
    reg [7:0]  act_cmd_ff;
    reg [12:0] op_cnt_ff;
    reg [9:0]  er_idx_ff;
    reg        chain_ff;
    reg [4:0]  row_ff;
    reg        protect_violation_bit_ff;
    reg        access_error_bit_ff;
    reg        ccf_q_ff;
    reg [6:0]  div_ff;
    reg        div_ld_ff;
    reg [9:0]  tb_cnt_ff;
    reg [2:0]  prot_ff;
    reg [2:0]  irq_st_ff;
    reg [2:0]  irq_en_ff;

    wire       setup  = PSEL & ~PENABLE;
    wire       wr     = PSEL & PENABLE & PWRITE;
    wire       is_arr = PADDR[15];
    wire [10:0] arr_idx = PADDR[12:2];
    wire       ccf    = ~act_v_ff & ~buf_v_ff;
    wire [7:0] status = {~buf_v_ff, ccf, protect_violation_bit_ff, access_error_bit_ff, 4'h0};

    function is_reg;
        input [15:0] a;
        input [15:0] off;
        begin
            is_reg = ~a[15] & (a == off);
        end
    endfunction

    function protected_at;
        input [10:0] a;
        input [2:0]  lim;
        begin
            protected_at = ({1'b0, a[10:9]} >= lim);
        end
    endfunction

    function cmd_ok;
        input [7:0] c;
        begin
            cmd_ok = (c == `FCS_CMD_BYTE_PROG) | (c == `FCS_CMD_PAGE_ERASE);
        end
    endfunction

    function is_prog;
        input [7:0] c;
        begin
            is_prog = (c == `FCS_CMD_BYTE_PROG);
        end
    endfunction

    wire w_div   = wr & is_reg(PADDR, `FCS_OFF_DIV);
    wire w_cmd   = wr & is_reg(PADDR, `FCS_OFF_CMD);
    wire w_stat  = wr & is_reg(PADDR, `FCS_OFF_STAT);
    wire w_arr   = wr & is_arr;
    wire abort   = w_stat & PWDATA[`FCS_ST_PROTECT_VIOLATION_BIT] & PWDATA[`FCS_ST_ACCESS_ERROR_BIT];
    wire launch  = w_stat & PWDATA[`FCS_ST_CBEF] & ~abort;
    wire w_prot  = wr & is_reg(PADDR, `FCS_OFF_PROT);
    wire w_ien   = wr & is_reg(PADDR, `FCS_OFF_IRQ_EN);
    wire w_iclr  = wr & is_reg(PADDR, `FCS_OFF_IRQ_CLR);

// ***************************************************
// timebase
// ***************************************************
    // prescale by eight when selected, then by divider value plus one
    // seven-bit sum so a divider of 63 does not wrap to zero
    wire [6:0] div_p1 = {1'b0, div_ff[5:0]} + 7'h01;
    wire [9:0] tb_lim = div_ff[`FCS_DIV_PRESCALE] ?
                        {div_p1, 3'b000} - 10'h001 :
                        {4'h0, div_ff[5:0]};
    wire       tick = div_ld_ff & (tb_cnt_ff == tb_lim);

    always @(posedge REF_CLK) begin
        if (RESET | ~div_ld_ff | tick) begin
            tb_cnt_ff <= 10'h000;
        end else begin
            tb_cnt_ff <= tb_cnt_ff + 10'h001;
        end
    end

// ***************************************************
// command sequence and buffer
// ***************************************************
    wire op_done = act_v_ff & tick & (op_cnt_ff == 13'h0000);
    wire load    = buf_v_ff & ~act_v_ff;
    wire is_prog_buf = is_prog(buf_cmd_ff);
    wire burst   = chain_ff & is_prog_buf & (buf_addr_ff[10:6] == row_ff);

    // access error causes, evaluated per write
    wire e_arr   = w_arr & (buf_v_ff | (seq_ff != SEQ_IDLE));
    wire e_cmd   = w_cmd & ((seq_ff != SEQ_ADDR) | ~cmd_ok(PWDATA[7:0]));
    wire e_lnch  = launch & ((seq_ff != SEQ_CMD) | ~div_ld_ff);
    wire e_acc   = e_arr | e_cmd | e_lnch;
    wire e_prot  = launch & ~e_lnch & protected_at(lat_addr_ff, prot_ff);
    wire queue   = launch & ~e_lnch & ~e_prot;

    always @(posedge REF_CLK) begin
        if (RESET) begin
            seq_ff      <= SEQ_IDLE;
            lat_addr_ff <= 11'h000;
            lat_data_ff <= 8'h00;
            lat_cmd_ff  <= 8'h00;
            buf_v_ff    <= 1'b0;
            buf_addr_ff <= 11'h000;
            buf_data_ff <= 8'h00;
            buf_cmd_ff  <= 8'h00;
        end else if (abort) begin
            seq_ff   <= SEQ_IDLE;
            buf_v_ff <= 1'b0;
        end else begin
            if (e_acc | e_prot) begin
                seq_ff <= SEQ_IDLE;
            end else begin
                case (seq_ff)
                    SEQ_IDLE: begin
                        if (w_arr) begin
                            seq_ff      <= SEQ_ADDR;
                            lat_addr_ff <= arr_idx;
                            lat_data_ff <= PWDATA[7:0];
                        end
                    end
                    SEQ_ADDR: begin
                        if (w_cmd) begin
                            seq_ff     <= SEQ_CMD;
                            lat_cmd_ff <= PWDATA[7:0];
                        end
                    end
                    SEQ_CMD: begin
                        if (queue) begin
                            seq_ff      <= SEQ_IDLE;
                            buf_v_ff    <= 1'b1;
                            buf_addr_ff <= lat_addr_ff;
                            buf_data_ff <= lat_data_ff;
                            buf_cmd_ff  <= lat_cmd_ff;
                        end
                    end
                    default: begin
                        seq_ff <= SEQ_IDLE;
                    end
                endcase
            end
            if (load) begin
                buf_v_ff <= 1'b0;
            end
        end
    end

// ***************************************************
// command processor
// ***************************************************
    wire erasing = act_v_ff & (act_cmd_ff == `FCS_CMD_PAGE_ERASE) & ~er_idx_ff[9];

    always @(posedge REF_CLK) begin
        if (RESET | abort) begin
            act_v_ff    <= 1'b0;
            act_addr_ff <= 11'h000;
            act_data_ff <= 8'h00;
            act_cmd_ff  <= 8'h00;
            op_cnt_ff   <= 13'h0000;
            er_idx_ff   <= 10'h000;
            chain_ff    <= 1'b0;
            row_ff      <= 5'h00;
        end else if (load) begin
            act_v_ff    <= 1'b1;
            act_addr_ff <= buf_addr_ff;
            act_data_ff <= buf_data_ff;
            act_cmd_ff  <= buf_cmd_ff;
            er_idx_ff   <= 10'h000;
            if (~is_prog_buf) begin
                op_cnt_ff <= `FCS_ERASE_TICKS;
            end else if (burst) begin
                op_cnt_ff <= `FCS_BURST_TICKS;
            end else begin
                op_cnt_ff <= `FCS_PROG_TICKS;
            end
        end else if (act_v_ff) begin
            if (erasing) begin
                er_idx_ff <= er_idx_ff + 10'h001;
            end
            if (op_done) begin
                act_v_ff <= 1'b0;
                // burst only holds if the next command is already waiting
                chain_ff <= buf_v_ff & is_prog(act_cmd_ff);
                row_ff   <= act_addr_ff[10:6];
            end else if (tick) begin
                op_cnt_ff <= op_cnt_ff - 13'h0001;
            end
        end else begin
            chain_ff <= 1'b0;
        end
    end

    // single write port: erase walk and program end never overlap
    always @(posedge REF_CLK) begin
        if (~RESET & ~abort & erasing) begin
            mem[{act_addr_ff[10:9], er_idx_ff[8:0]}] <= `FCS_ERASED_BYTE;
        end else if (~RESET & ~abort & op_done &
                     is_prog(act_cmd_ff)) begin
            mem[act_addr_ff] <= mem[act_addr_ff] & act_data_ff;
        end
    end

// ***************************************************
// status flags, divider, protection
// ***************************************************
    always @(posedge REF_CLK) begin
        if (RESET) begin
            protect_violation_bit_ff  <= 1'b0;
            access_error_bit_ff <= 1'b0;
            ccf_q_ff  <= 1'b1;
            div_ff    <= `FCS_DIV_RST;
            div_ld_ff <= 1'b0;
            prot_ff   <= `FCS_PROT_RST;
        end else begin
            ccf_q_ff <= ccf;
            // new errors win over a clear in the same cycle
            protect_violation_bit_ff  <= e_prot | (protect_violation_bit_ff & ~abort);
            access_error_bit_ff <= e_acc  | (access_error_bit_ff & ~abort);
            if (w_div & ~div_ld_ff) begin
                div_ff    <= PWDATA[6:0];
                div_ld_ff <= 1'b1;
            end
            if (w_prot) begin
                prot_ff <= PWDATA[2:0];
            end
        end
    end

// ***************************************************
// interrupts
// ***************************************************
    wire [2:0] irq_ev = {e_acc, e_prot, ccf & ~ccf_q_ff};
    wire [2:0] irq_clr = w_iclr ? PWDATA[2:0] : 3'h0;
    wire [2:0] nxt_irq_st;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_irq
            // an event in the clearing cycle wins over the clear
            assign nxt_irq_st[gi] = irq_ev[gi] | (irq_st_ff[gi] & ~irq_clr[gi]);
        end
    endgenerate

    always @(posedge REF_CLK) begin
        if (RESET) begin
            irq_st_ff <= 3'h0;
            irq_en_ff <= 3'h0;
        end else begin
            irq_st_ff <= nxt_irq_st;
            if (w_ien) begin
                irq_en_ff <= PWDATA[2:0];
            end
        end
    end

    assign IRQ = |(irq_st_ff & irq_en_ff);

// ***************************************************
// apb read path
// ***************************************************
    // data sampled in setup, so every access completes with no wait
    assign PREADY = 1'b1;

    reg [31:0] rd_val;
    reg        rd_err;

    always @* begin
        rd_val = 32'h00000000;
        rd_err = 1'b0;
        if (is_arr) begin
            if (~PWRITE & ~ccf) begin
                rd_err = 1'b1;
            end else if (~PWRITE) begin
                rd_val = {24'h000000, mem[arr_idx]};
            end
        end else begin
            case (PADDR)
                `FCS_OFF_DIV:      rd_val = {24'h000000, div_ld_ff, div_ff};
                `FCS_OFF_CMD:      rd_val = {24'h000000, lat_cmd_ff};
                `FCS_OFF_STAT:     rd_val = {24'h000000, status};
                `FCS_OFF_PROT:     rd_val = {29'h0000000, prot_ff};
                `FCS_OFF_IRQ_STAT: rd_val = {29'h0000000, irq_st_ff};
                `FCS_OFF_IRQ_EN:   rd_val = {29'h0000000, irq_en_ff};
                `FCS_OFF_IRQ_CLR:  rd_val = 32'h00000000;
                default:           rd_err = 1'b1;
            endcase
        end
    end

    always @(posedge REF_CLK) begin
        if (RESET) begin
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else if (setup) begin
            PRDATA  <= PWRITE ? 32'h00000000 : rd_val;
            PSLVERR <= rd_err;
        end
    end

endmodule

`default_nettype wire

// *** rtl/fcs_map.vh ***
/*
 * Address map, field positions, reset values and timing counts for the
 * flash command sequencer.
 * Assumes a 32-bit APB with byte addresses and a 20 MHz REF_CLK.
 */
`ifndef FCS_MAP_VH
`define FCS_MAP_VH

// ***************************************************
// register offsets
// ***************************************************
`define FCS_OFF_DIV        16'h0000
`define FCS_OFF_CMD        16'h0004
`define FCS_OFF_STAT       16'h0008
`define FCS_OFF_PROT       16'h000C
`define FCS_OFF_IRQ_STAT   16'h0010
`define FCS_OFF_IRQ_EN     16'h0014
`define FCS_OFF_IRQ_CLR    16'h0018
`define FCS_ARRAY_BASE     16'h8000

// ***************************************************
// fields
// ***************************************************
`define FCS_ST_CBEF        7
`define FCS_ST_CCF         6
`define FCS_ST_PROTECT_VIOLATION_BIT       5
`define FCS_ST_ACCESS_ERROR_BIT      4
`define FCS_DIV_LOADED     7
`define FCS_DIV_PRESCALE   6
`define FCS_IRQ_DONE       0
`define FCS_IRQ_PROTECT_VIOLATION_BIT      1
`define FCS_IRQ_ACCESS_ERROR_BIT     2

// ***************************************************
// codes and reset values
// ***************************************************
`define FCS_CMD_BYTE_PROG  8'h20
`define FCS_CMD_PAGE_ERASE 8'h40
`define FCS_ERASED_BYTE    8'hFF
`define FCS_PROT_RST       3'h4
`define FCS_DIV_RST        7'h00

// ***************************************************
// timing in timebase ticks
// ***************************************************
`define FCS_PROG_TICKS     13'h0009
`define FCS_BURST_TICKS    13'h0002
`define FCS_ERASE_TICKS    13'h0FA0

`endif

// *** verification/fcs_flash_cmd_seq_asserts.sv ***
/* checker for the flash command sequencer ports
   assumes the register map header and one REF_CLK domain */
`timescale 1ns/1ps
`default_nettype none
`include "fcs_map.vh"
module fcs_flash_cmd_seq_asserts (
    input wire logic        REF_CLK,
    input wire logic        RESET,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic [31:0] PRDATA,
    input wire logic        PSLVERR,
    input wire logic        IRQ
);
    // ******************
    // shadow state
    // ******************
    // done trusted from reset and once a status read showed it; any status write voids it
    logic       done_ff;
    logic [2:0] irqen_ff;
    logic       divld_ff;
    logic [6:0] div_ff;
    always @(posedge REF_CLK) begin
        if (RESET) begin
            done_ff  <= 1'b1;
            irqen_ff <= 3'h0;
            divld_ff <= 1'b0;
            div_ff   <= 7'h00;
        end else if (PSEL && PENABLE) begin
            if (PWRITE && PADDR == `FCS_OFF_STAT) done_ff <= 1'b0;
            if (!PWRITE && PADDR == `FCS_OFF_STAT && PRDATA[6]) done_ff <= 1'b1;
            if (PWRITE && PADDR == `FCS_OFF_IRQ_EN) irqen_ff <= PWDATA[2:0];
            if (PWRITE && PADDR == `FCS_OFF_DIV && !divld_ff) begin
                divld_ff <= 1'b1;
                div_ff   <= PWDATA[6:0];
            end
        end
    end
    // ******************
    // properties
    // ******************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    sequence rd_setup(logic [15:0] a);
        PSEL && !PENABLE && !PWRITE && PADDR == a;
    endsequence
    sequence wr_acc(logic [15:0] a);
        PSEL && PENABLE && PWRITE && PADDR == a;
    endsequence
    AST_READY: assert property (PREADY)
        else $error("ready low");
    AST_UNMAPPED: assert property (PSEL && !PENABLE && !PWRITE && !PADDR[15]
        && PADDR[14:0] >= 15'h0020 |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped read accepted");
    AST_STAT_FIELDS: assert property (rd_setup(`FCS_OFF_STAT) |=>
        PRDATA[31:8] == 24'h0 && PRDATA[3:0] == 4'h0)
        else $error("status bits outside flags");
    AST_ARRAY_BACK: assert property (PSEL && !PENABLE && !PWRITE && PADDR[15] && done_ff
        |=> !PSLVERR)
        else $error("array refused after completion");
    AST_DIV_ONCE: assert property (rd_setup(`FCS_OFF_DIV) |=>
        PRDATA == {24'h0, divld_ff, div_ff})
        else $error("divider not write once");
    AST_IRQ_EN: assert property (IRQ |-> irqen_ff != 3'h0)
        else $error("irq with nothing enabled");
    AST_IRQ_CLEAR: assert property (wr_acc(`FCS_OFF_IRQ_CLR) ##0
        (PWDATA[2:0] == 3'h7 && done_ff) |=> !IRQ)
        else $error("irq survives clear");
    AST_CLR_RD: assert property (rd_setup(`FCS_OFF_IRQ_CLR) |=> PRDATA == 32'h0)
        else $error("clear register reads nonzero");
    AST_REFUSED_ZERO: assert property (PSEL && PENABLE && !PWRITE && PSLVERR
        |-> PRDATA == 32'h0)
        else $error("refused read returns data");
endmodule
bind fcs_flash_cmd_seq fcs_flash_cmd_seq_asserts fcs_flash_cmd_seq_asserts_i (.REF_CLK,
    .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PRDATA, .PSLVERR, .IRQ);
`default_nettype wire

// *** verification/fcs_flash_cmd_seq_bench.sv ***
/* bench: byte array model, error, burst and interrupt scenarios
   assumes the host model and the bound checker */
`timescale 1ns/1ps
`default_nettype none
`include "fcs_map.vh"
module fcs_flash_cmd_seq_bench;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, irq;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  s, d;
    int          failures = 0, compares = 0, cyc = 0, t1, t2, seed, mem [2048];
    fcs_flash_cmd_seq fcs_flash_cmd_seq_i (.REF_CLK(ref_clk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .IRQ(irq));
    fcs_host_model fcs_host_model_i (.clk(ref_clk), .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr);
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    // ******************
    // helpers
    // ******************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        fcs_host_model_i.xfer(1'b1, a, {24'h0, v});
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        fcs_host_model_i.xfer(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), fcs_host_model_i.q, exp);
    endtask
    task automatic arr(input int n);
        fcs_host_model_i.xfer(1'b0, `FCS_ARRAY_BASE | 16'(n * 4), 32'h0);
        chk("array err", {31'h0, fcs_host_model_i.e}, 32'h0);
        if (mem[n] >= 0) chk($sformatf("byte %0d", n), fcs_host_model_i.q, 32'(mem[n]));
    endtask
    task automatic go(input int n, input logic [7:0] v, input logic [7:0] c);
        fcs_host_model_i.seq(11'(n), v, c);
    endtask
    task automatic done(input logic [7:0] exp);
        fcs_host_model_i.poll(s);
        chk("status flags", {24'h0, s & 8'h70}, {24'h0, exp});
    endtask
    task automatic irqis(input logic v);
        #1;
        chk("irq", {31'h0, irq}, {31'h0, v});
    endtask
    // cnt programs in one row; t runs from first launch to the done interrupt
    task automatic burst(input int n, input int cnt, output int t);
        for (int i = 0; i < cnt; i++) begin
            d = 8'($random(seed));
            go(n + i, d, `FCS_CMD_BYTE_PROG);
            if (i == 0) t = cyc;
            mem[n + i] = mem[n + i] & d;
        end
        while (irq !== 1'b1) @(posedge ref_clk);
        t = cyc - t;
        done(8'h40);
        for (int i = 0; i < cnt; i++) arr(n + i);
        wr(`FCS_OFF_IRQ_CLR, 8'h07);
    endtask
    task automatic complete_run;
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ******************
    // scenarios
    // ******************
    initial begin
        seed = 32'h4e548f9c;
        foreach (mem[i]) mem[i] = -1;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        rd(`FCS_OFF_STAT, 32'hC0);
        go(0, 8'h00, `FCS_CMD_BYTE_PROG);
        done(8'h50);
        wr(`FCS_OFF_STAT, 8'h30);
        wr(`FCS_OFF_DIV, 8'h03);
        wr(`FCS_OFF_DIV, 8'h3F);
        rd(`FCS_OFF_DIV, 32'h83);
        wr(`FCS_OFF_CMD, `FCS_CMD_BYTE_PROG);
        wr(`FCS_OFF_STAT, 8'h80);
        done(8'h50);
        wr(`FCS_OFF_STAT, 8'h30);
        rd(`FCS_OFF_STAT, 32'hC0);
        rd(16'h0040, 32'h0);
        chk("unmapped err", {31'h0, fcs_host_model_i.e}, 32'h1);
        rd(`FCS_OFF_IRQ_CLR, 32'h0);
        wr(`FCS_OFF_IRQ_CLR, 8'h07);
        go(0, 8'hFF, `FCS_CMD_PAGE_ERASE);
        repeat (4) @(posedge ref_clk);
        fcs_host_model_i.xfer(1'b0, `FCS_OFF_STAT, 32'h0);
        chk("busy", fcs_host_model_i.q & 32'h40, 32'h0);
        fcs_host_model_i.xfer(1'b0, `FCS_ARRAY_BASE | 16'h0014, 32'h0);
        chk("busy array err", {31'h0, fcs_host_model_i.e}, 32'h1);
        done(8'h40);
        for (int i = 0; i < 512; i++) mem[i] = 255;
        arr(0);
        arr(511);
        irqis(1'b0);
        rd(`FCS_OFF_IRQ_STAT, 32'h1);
        wr(`FCS_OFF_IRQ_EN, 8'h01);
        irqis(1'b1);
        wr(`FCS_OFF_IRQ_CLR, 8'h07);
        irqis(1'b0);
        burst(7, 1, t1);
        burst(8, 2, t2);
        chk("queued", 32'(t2 > t1 + 1), 32'h1);
        chk("burst", 32'(2 * (t2 - t1) < t1), 32'h1);
        wr(`FCS_OFF_PROT, 8'h03);
        rd(`FCS_OFF_PROT, 32'h3);
        go(1536, 8'hFF, `FCS_CMD_PAGE_ERASE);
        done(8'h60);
        wr(`FCS_OFF_STAT, 8'h30);
        go(512, 8'hFF, `FCS_CMD_PAGE_ERASE);
        repeat (20) @(posedge ref_clk);
        wr(`FCS_OFF_STAT, 8'h30);
        repeat (4) @(posedge ref_clk);
        rd(`FCS_OFF_STAT, 32'hC0);
        arr(7);
        complete_run;
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        complete_run;
    end
endmodule
`default_nettype wire

// *** verification/fcs_host_model.sv ***
/* host model: apb master and the three-step flash command
   assumes the caller is at a rising edge of clk */
`timescale 1ns/1ps
`default_nettype none
`include "fcs_map.vh"
module fcs_host_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [15:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    logic [31:0] q;
    logic        e;
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 16'h0000;
        pwdata  = 32'h0;
    end
    // ******************
    // bus cycle
    // ******************
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released lines flip so stale values never look valid
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
    task automatic seq(input logic [10:0] n, input logic [7:0] d, input logic [7:0] c);
        xfer(1'b1, `FCS_ARRAY_BASE | {3'h0, n, 2'h0}, {24'h0, d});
        xfer(1'b1, `FCS_OFF_CMD, {24'h0, c});
        xfer(1'b1, `FCS_OFF_STAT, 32'h80);
    endtask
    // polls status only, never the array, as if running from ram
    task automatic poll(output logic [7:0] s);
        repeat (4) @(posedge clk);
        s = 8'h00;
        while (s[6] !== 1'b1) begin
            xfer(1'b0, `FCS_OFF_STAT, 32'h0);
            s = q[7:0];
        end
    endtask
endmodule
`default_nettype wire
